// ### core/dcpm_regs.sv
`timescale 1ns/10ps
`include "dcpm_params.svh"

module dcpm_regs
  import dcpm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic controller_reset_n_in,
  input dcpm_cfg_req_s cfg_req_in,
  output logic [7:0] cfg_rdata_out,
  output logic cfg_ack_out,
  output dcpm_dock_pins_s dock_pins_out,
  output logic dock_mated_out
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic dock_attach_reg;
  logic dock_attach_next;
  logic docking_supported_reg;
  logic docking_supported_next;
  logic ds_written_reg;
  logic ds_written_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic ack_reg;
  wire logic ctl_clear;
  wire logic wr_control;
  wire logic wr_status;
  wire logic dock_mated;
  wire logic seq_busy;
  wire logic [15:0] power_caps;
  wire logic addr_mapped;
  logic [6:0] seq_age_reg;
  logic [6:0] seq_age_next;

  assign ctl_clear = !controller_reset_n_in;
  assign wr_control = cfg_req_in.wr && hit(cfg_req_in.addr, `DCPM_OFF_DOCK_CONTROL);
  assign wr_status = cfg_req_in.wr && hit(cfg_req_in.addr, `DCPM_OFF_DOCK_STATUS);
  assign power_caps = {`DCPM_VAL_PME_SUPPORT, 8'h00, `DCPM_VAL_CAP_VERSION};

  // Any byte outside this list reads as zero and swallows writes.
  assign addr_mapped = hit(cfg_req_in.addr, `DCPM_OFF_CAP_PTR) || hit(cfg_req_in.addr, `DCPM_OFF_DOCK_CONTROL) ||
    hit(cfg_req_in.addr, `DCPM_OFF_DOCK_STATUS) || hit(cfg_req_in.addr, `DCPM_OFF_POWER_CAP_ID) ||
    hit(cfg_req_in.addr, `DCPM_OFF_NEXT_CAP) || hit(cfg_req_in.addr, `DCPM_OFF_POWER_CAP_LO) ||
    hit(cfg_req_in.addr, `DCPM_OFF_POWER_CAP_HI);

  // Writes only move the attach bit while docking is supported; a controller reset clears it regardless.
  assign dock_attach_next = ctl_clear ? 1'b0 :
    (wr_control && docking_supported_reg) ? cfg_req_in.wdata[`DCPM_BIT_DOCK_ATTACH] : dock_attach_reg;

  // Write-once bit: the controller reset does not touch it, so it lives on rst_in alone.
  assign docking_supported_next = (wr_status && !ds_written_reg) ?
    cfg_req_in.wdata[`DCPM_BIT_DOCKING_SUPPORTED] : docking_supported_reg;
  assign ds_written_next = ds_written_reg || wr_status;

  always_comb
  begin
    rdata_next = 8'h00;
    if (cfg_req_in.rd)
    begin
      case (cfg_req_in.addr)
        `DCPM_OFF_CAP_PTR: rdata_next = `DCPM_VAL_CAP_PTR;
        `DCPM_OFF_DOCK_CONTROL: rdata_next = {7'h00, dock_attach_reg};
        `DCPM_OFF_DOCK_STATUS: rdata_next = {docking_supported_reg, 6'h00, dock_mated};
        `DCPM_OFF_POWER_CAP_ID: rdata_next = `DCPM_VAL_POWER_CAP_ID;
        `DCPM_OFF_NEXT_CAP: rdata_next = `DCPM_VAL_NEXT_CAP;
        `DCPM_OFF_POWER_CAP_LO: rdata_next = power_caps[7:0];
        `DCPM_OFF_POWER_CAP_HI: rdata_next = power_caps[15:8];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      docking_supported_reg <= 1'(`DCPM_RST_DOCK_STATUS >> `DCPM_BIT_DOCKING_SUPPORTED);
      ds_written_reg <= 1'b0;
    end
    else
    begin
      docking_supported_reg <= docking_supported_next;
      ds_written_reg <= ds_written_next;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dock_attach_reg <= 1'b0;
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
    end
    else
    begin
      dock_attach_reg <= dock_attach_next;
      rdata_reg <= rdata_next;
      ack_reg <= cfg_req_in.rd || cfg_req_in.wr;
    end
  end

  // Sequencer follows the attach level; a write that flips it mid-sequence is
  // honoured once the current sequence ends, which keeps the pins glitch free.
  dcpm_dock_seq u_seq (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ctl_clear_in(ctl_clear),
    .attach_in(dock_attach_reg),
    .pins_out(dock_pins_out),
    .mated_out(dock_mated),
    .busy_out(seq_busy)
  );

  assign cfg_rdata_out = rdata_reg;
  assign cfg_ack_out = ack_reg;
  assign dock_mated_out = dock_mated;

  // Age of the running dock or undock sequence, saturating. It bounds the
  // sequence length far more cheaply than a long repeated check would.
  assign seq_age_next = !seq_busy ? 7'h00 :
    (seq_age_reg == 7'h7f) ? seq_age_reg : seq_age_reg + 7'h01;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      seq_age_reg <= 7'h00;
    end
    else
    begin
      seq_age_reg <= seq_age_next;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  AST_DOCK_START: assert property (
    $rose(dock_attach_reg) && !dock_mated && !seq_busy && controller_reset_n_in
    |=> !dock_pins_out.dock_enable_n && !dock_pins_out.dock_reset_n)
    else $error("Docking sequence did not start.");

  AST_DOCK_DONE: assert property (
    $rose(dock_mated) |-> dock_attach_reg && dock_pins_out.dock_reset_n && !dock_pins_out.dock_enable_n)
    else $error("Dock mated set without completed docking.");

  AST_DOCK_TIME: assert property (
    $rose(dock_attach_reg) && !dock_mated && !seq_busy && controller_reset_n_in
    |-> ##[1:60] (dock_mated || !controller_reset_n_in || !dock_attach_reg))
    else $error("Docking did not finish in time.");

  AST_UNDOCK_TIME: assert property (
    $fell(dock_attach_reg) && dock_mated && !seq_busy && controller_reset_n_in
    |-> ##[1:60] (!dock_mated || dock_attach_reg))
    else $error("Undocking did not finish in time.");

  AST_SEQ_BOUND: assert property (
    seq_age_reg <= 7'(2 * (`DCPM_STEP_CYC + 1)))
    else $error("Dock sequence ran too long.");

  AST_UNDOCK_START: assert property (
    $fell(dock_attach_reg) && dock_mated && !seq_busy && controller_reset_n_in
    |=> !dock_pins_out.dock_reset_n && !dock_pins_out.dock_enable_n)
    else $error("Undocking sequence did not start.");

  AST_UNDOCK_DONE: assert property (
    $fell(dock_mated) && controller_reset_n_in && $past(controller_reset_n_in)
    |-> dock_pins_out.dock_enable_n && !dock_pins_out.dock_reset_n && !dock_attach_reg)
    else $error("Dock mated cleared without completed undocking.");

  AST_ATTACH_LOCKED: assert property (
    !docking_supported_reg && controller_reset_n_in |=> $stable(dock_attach_reg))
    else $error("Attach bit changed while docking unsupported.");

  AST_DS_ONCE: assert property (
    ds_written_reg |=> $stable(docking_supported_reg))
    else $error("Docking supported changed after its one write.");

  AST_DS_CTL_RESET: assert property (
    ctl_clear |=> docking_supported_reg == $past(docking_supported_reg) || $past(wr_status && !ds_written_reg))
    else $error("Controller reset disturbed docking supported.");

  AST_MATED_READ: assert property (
    cfg_req_in.rd && hit(cfg_req_in.addr, `DCPM_OFF_DOCK_STATUS)
    |=> cfg_rdata_out[`DCPM_BIT_DOCK_MATED] == $past(dock_mated) && cfg_rdata_out[6:1] == 6'h00)
    else $error("Dock status read wrong.");

  AST_CAP_ID: assert property (
    cfg_req_in.rd && hit(cfg_req_in.addr, `DCPM_OFF_POWER_CAP_ID) |=> cfg_rdata_out == 8'h01 && cfg_ack_out)
    else $error("Capability ID wrong.");

  AST_NEXT_CAP: assert property (
    cfg_req_in.rd && hit(cfg_req_in.addr, `DCPM_OFF_NEXT_CAP) |=> cfg_rdata_out == 8'h70)
    else $error("Next capability wrong.");

  AST_PME_SUPPORT: assert property (
    cfg_req_in.rd && hit(cfg_req_in.addr, `DCPM_OFF_POWER_CAP_HI) |=> cfg_rdata_out == 8'h48)
    else $error("PME support field wrong.");

  AST_CAP_VERSION: assert property (
    cfg_req_in.rd && hit(cfg_req_in.addr, `DCPM_OFF_POWER_CAP_LO) |=> cfg_rdata_out == 8'h02)
    else $error("Capability version wrong.");

  AST_CAP_PTR: assert property (
    cfg_req_in.rd && hit(cfg_req_in.addr, `DCPM_OFF_CAP_PTR) |=> cfg_rdata_out == 8'h50)
    else $error("Capabilities pointer wrong.");

  AST_DOCK_ORDER: assert property (
    $rose(dock_pins_out.dock_reset_n) |-> !dock_pins_out.dock_enable_n && $past(!dock_pins_out.dock_enable_n, 25))
    else $error("Reset released before enable settled.");

  AST_UNDOCK_ORDER: assert property (
    $rose(dock_pins_out.dock_enable_n) && controller_reset_n_in && $past(controller_reset_n_in)
    |-> !dock_pins_out.dock_reset_n && $past(!dock_pins_out.dock_reset_n, 25))
    else $error("Enable dropped before reset asserted.");

  AST_ATTACH_WRITE: assert property (
    wr_control && docking_supported_reg && controller_reset_n_in
    |=> dock_attach_reg == $past(cfg_req_in.wdata[`DCPM_BIT_DOCK_ATTACH]))
    else $error("Attach bit did not take the written value.");

  AST_ATTACH_READ: assert property (
    cfg_req_in.rd && hit(cfg_req_in.addr, `DCPM_OFF_DOCK_CONTROL)
    |=> cfg_rdata_out == {7'h00, $past(dock_attach_reg)})
    else $error("Dock control read wrong.");

  AST_DS_FIRST_WRITE: assert property (
    wr_status && !ds_written_reg
    |=> ds_written_reg && docking_supported_reg == $past(cfg_req_in.wdata[`DCPM_BIT_DOCKING_SUPPORTED]))
    else $error("First docking supported write not taken.");

  AST_DS_READ: assert property (
    cfg_req_in.rd && hit(cfg_req_in.addr, `DCPM_OFF_DOCK_STATUS)
    |=> cfg_rdata_out[`DCPM_BIT_DOCKING_SUPPORTED] == $past(docking_supported_reg))
    else $error("Docking supported read wrong.");

  AST_MATED_HOLD: assert property (
    !seq_busy && controller_reset_n_in |=> $stable(dock_mated))
    else $error("Dock mated moved outside a sequence.");

  // Outside a sequence the pins must match the reported mated state.
  AST_LINK_DOCKED: assert property (
    dock_mated && !seq_busy |-> !dock_pins_out.dock_enable_n && dock_pins_out.dock_reset_n)
    else $error("Dock mated without an active link.");

  AST_LINK_IDLE: assert property (
    !dock_mated && !seq_busy |-> dock_pins_out.dock_enable_n && !dock_pins_out.dock_reset_n)
    else $error("Link active while undocked.");

  AST_ENABLE_FIRST: assert property (
    $fell(dock_pins_out.dock_enable_n) |-> !dock_pins_out.dock_reset_n && !dock_mated)
    else $error("Enable asserted with reset already released.");

  AST_MATED_LAST: assert property (
    $fell(dock_pins_out.dock_reset_n) && controller_reset_n_in && $past(controller_reset_n_in)
    |-> dock_mated && !dock_pins_out.dock_enable_n)
    else $error("Dock mated cleared before undocking reset.");

  // The config port answers every access exactly one cycle later.
  AST_ACK_PULSE: assert property (
    cfg_req_in.rd || cfg_req_in.wr |=> cfg_ack_out)
    else $error("Config access not acknowledged.");

  AST_ACK_IDLE: assert property (
    !cfg_req_in.rd && !cfg_req_in.wr |=> !cfg_ack_out && cfg_rdata_out == 8'h00)
    else $error("Config answer without a request.");

  AST_UNMAPPED_READ: assert property (
    cfg_req_in.rd && !addr_mapped |=> cfg_rdata_out == 8'h00)
    else $error("Unmapped byte read not zero.");

  AST_CTL_IDLE: assert property (
    !controller_reset_n_in
    |=> dock_pins_out.dock_enable_n && !dock_pins_out.dock_reset_n && !dock_mated && !dock_attach_reg)
    else $error("Controller reset left the dock link active.");

  COV_DOCK: cover property ($rose(dock_mated));
  COV_CTL_RESET_DOCKED: cover property (!controller_reset_n_in && dock_mated);
  COV_UNDOCK: cover property ($fell(dock_mated) && controller_reset_n_in);
  COV_DS_CLEARED: cover property (ds_written_reg && !docking_supported_reg);
  COV_LOCKED_WRITE: cover property (wr_control && !docking_supported_reg);

endmodule // dcpm_regs

// ### core/dcpm_params.svh
`ifndef DCPM_PARAMS_SVH
`define DCPM_PARAMS_SVH

// Configuration byte offsets.
`define DCPM_OFF_CAP_PTR 8'h34
`define DCPM_OFF_DOCK_CONTROL 8'h4c
`define DCPM_OFF_DOCK_STATUS 8'h4d
`define DCPM_OFF_POWER_CAP_ID 8'h50
`define DCPM_OFF_NEXT_CAP 8'h51
`define DCPM_OFF_POWER_CAP_LO 8'h52
`define DCPM_OFF_POWER_CAP_HI 8'h53

// Field positions.
`define DCPM_BIT_DOCK_ATTACH 0
`define DCPM_BIT_DOCK_MATED 0
`define DCPM_BIT_DOCKING_SUPPORTED 7

// Reset and hardwired values.
`define DCPM_RST_DOCK_CONTROL 8'h00
`define DCPM_RST_DOCK_STATUS 8'h80
`define DCPM_VAL_CAP_PTR 8'h50
`define DCPM_VAL_POWER_CAP_ID 8'h01
`define DCPM_VAL_NEXT_CAP 8'h70
`define DCPM_VAL_PME_SUPPORT 5'h09
`define DCPM_VAL_CAP_VERSION 3'h2
`define DCPM_VAL_POWER_CAP 16'h4802

// Dock pin sequencing.
`define DCPM_CLK_NS 40
`define DCPM_STEP_NS 1000
`define DCPM_STEP_CYC ((`DCPM_STEP_NS + `DCPM_CLK_NS - 1) / `DCPM_CLK_NS)

`endif

// ### core/dcpm_pkg.sv
package dcpm_pkg;

  typedef enum logic [2:0] {
    SEQ_UNDOCKED,
    SEQ_EN_WAIT,
    SEQ_RST_WAIT,
    SEQ_DOCKED,
    SEQ_URST_WAIT,
    SEQ_UEN_WAIT
  } dcpm_seq_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dcpm_cfg_req_s;

  typedef struct packed {
    logic dock_enable_n;
    logic dock_reset_n;
  } dcpm_dock_pins_s;

  typedef logic [7:0] dcpm_cnt_t;

endpackage

// ### core/dcpm_dock_seq.sv
`timescale 1ns/10ps
`include "dcpm_params.svh"

module dcpm_dock_seq
  import dcpm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ctl_clear_in,
  input wire logic attach_in,
  output dcpm_dock_pins_s pins_out,
  output logic mated_out,
  output logic busy_out
);

  localparam dcpm_cnt_t STEP = dcpm_cnt_t'(`DCPM_STEP_CYC);

  dcpm_seq_e state_reg;
  dcpm_seq_e state_next;
  dcpm_cnt_t cnt_reg;
  dcpm_cnt_t cnt_next;
  dcpm_dock_pins_s pins_reg;
  dcpm_dock_pins_s pins_next;
  logic mated_reg;
  logic mated_next;
  wire logic cnt_done;

  assign cnt_done = (cnt_reg == 8'h00);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_done ? cnt_reg : cnt_reg - 8'h01;
    pins_next = pins_reg;
    mated_next = mated_reg;
    case (state_reg)
      SEQ_UNDOCKED:
      begin
        if (attach_in)
        begin
          // Enable goes active first while reset still holds the codec.
          state_next = SEQ_EN_WAIT;
          pins_next.dock_enable_n = 1'b0;
          cnt_next = STEP;
        end
      end
      SEQ_EN_WAIT:
      begin
        if (cnt_done)
        begin
          state_next = SEQ_RST_WAIT;
          pins_next.dock_reset_n = 1'b1;
          cnt_next = STEP;
        end
      end
      SEQ_RST_WAIT:
      begin
        if (cnt_done)
        begin
          state_next = SEQ_DOCKED;
          mated_next = 1'b1;
        end
      end
      SEQ_DOCKED:
      begin
        if (!attach_in)
        begin
          state_next = SEQ_URST_WAIT;
          pins_next.dock_reset_n = 1'b0;
          cnt_next = STEP;
        end
      end
      SEQ_URST_WAIT:
      begin
        if (cnt_done)
        begin
          state_next = SEQ_UEN_WAIT;
          pins_next.dock_enable_n = 1'b1;
          cnt_next = STEP;
        end
      end
      SEQ_UEN_WAIT:
      begin
        if (cnt_done)
        begin
          state_next = SEQ_UNDOCKED;
          mated_next = 1'b0;
        end
      end
      default:
      begin
        state_next = SEQ_UNDOCKED;
      end
    endcase
    // A controller reset drops the link to the idle undocked pin state at once.
    if (ctl_clear_in)
    begin
      state_next = SEQ_UNDOCKED;
      cnt_next = 8'h00;
      pins_next.dock_enable_n = 1'b1;
      pins_next.dock_reset_n = 1'b0;
      mated_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= SEQ_UNDOCKED;
      cnt_reg <= 8'h00;
      pins_reg <= '{dock_enable_n: 1'b1, dock_reset_n: 1'b0};
      mated_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pins_reg <= pins_next;
      mated_reg <= mated_next;
    end
  end

  assign pins_out = pins_reg;
  assign mated_out = mated_reg;
  assign busy_out = (state_reg != SEQ_UNDOCKED) && (state_reg != SEQ_DOCKED);

endmodule // dcpm_dock_seq

// ### dv/dcpm_codec_model.sv
`timescale 1ns/10ps

module dcpm_codec_model
  import dcpm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input dcpm_dock_pins_s pins_in,
  output logic linked_out,
  output logic order_err_out
);
  dcpm_dock_pins_s last_reg;
  logic order_bad;

  // The codec only joins the link while it is powered and out of reset.
  assign linked_out = !pins_in.dock_enable_n && pins_in.dock_reset_n;
  // Leaving reset unpowered, or losing power out of reset, can latch up the codec.
  assign order_bad = (pins_in.dock_reset_n && !last_reg.dock_reset_n && pins_in.dock_enable_n) ||
                     (pins_in.dock_enable_n && !last_reg.dock_enable_n && pins_in.dock_reset_n);

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      last_reg <= '{dock_enable_n: 1'b1, dock_reset_n: 1'b0};
      order_err_out <= 1'b0;
    end
    else
    begin
      last_reg <= pins_in;
      if (order_bad)
      begin
        order_err_out <= 1'b1;
      end
    end
  end
endmodule // dcpm_codec_model

// ### dv/dock_control_pm_capability_regs_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module dock_control_pm_capability_regs_tb;
  import dcpm_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic controller_reset_n_in = 1'b1;
  dcpm_cfg_req_s cfg_req = '0;
  logic [7:0] cfg_rdata;
  logic cfg_ack;
  dcpm_dock_pins_s pins;
  logic mated;
  logic linked;
  logic order_err;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  logic [7:0] addr_tab [8] = '{8'h34, 8'h4c, 8'h4d, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
  logic [7:0] exp_tab [8] = '{8'h50, 8'h00, 8'h80, 8'h01, 8'h70, 8'h02, 8'h48, 8'h00};

  dcpm_regs u_dut (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .controller_reset_n_in(controller_reset_n_in),
    .cfg_req_in(cfg_req),
    .cfg_rdata_out(cfg_rdata),
    .cfg_ack_out(cfg_ack),
    .dock_pins_out(pins),
    .dock_mated_out(mated)
  );

  dcpm_codec_model u_codec (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pins_in(pins),
    .linked_out(linked),
    .order_err_out(order_err)
  );

  initial
  begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cfg_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int i;
    @(negedge clk_sys_in);
    cfg_req = '{rd: !wr, wr: wr, addr: a, wdata: d};
    @(negedge clk_sys_in);
    cfg_req = '0;
    i = 0;
    while (cfg_ack !== 1'b1 && i < 4)
    begin
      @(negedge clk_sys_in);
      i++;
    end
    if (cfg_ack !== 1'b1)
    begin
      error_cnt++;
      $display("[FAIL] cfg_ack exp 1 got %b", cfg_ack);
      stop_test();
    end
    q = cfg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] q;
    cfg_xfer(1'b0, a, 8'h00, q);
    `CHK($sformatf("cfg 0x%h", a), ex, q)
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    cfg_xfer(1'b1, a, d, q);
  endtask

  function automatic logic lvl(input int s);
    return (s == 0) ? pins.dock_enable_n : (s == 1) ? pins.dock_reset_n : mated;
  endfunction

  // Counts falling edges until the selected output reaches the level.
  task automatic wait_lvl(input int s, input logic v, output int k);
    k = 0;
    while (lvl(s) !== v && k < 200)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    if (k == 200)
    begin
      error_cnt++;
      $display("[FAIL] dock output %0d exp %b timed out", s, v);
      stop_test();
    end
  endtask

  task automatic dock;
    rd_chk(8'h4d, 8'h80);
    wr(8'h4c, 8'h01);
    wait_lvl(0, 1'b0, n);
    `CHK("reset_n at enable", 1'b0, pins.dock_reset_n)
    wait_lvl(1, 1'b1, n);
    `CHK("enable to release", 26, n)
    `CHK("mated early", 1'b0, mated)
    wait_lvl(2, 1'b1, n);
    `CHK("release to mated", 26, n)
    `CHK("codec linked", 1'b1, linked)
    rd_chk(8'h4d, 8'h81);
    $display("test dock done");
  endtask

  task automatic undock;
    rd_chk(8'h4d, 8'h81);
    wr(8'h4c, 8'h00);
    wait_lvl(1, 1'b0, n);
    `CHK("enable_n at reset", 1'b0, pins.dock_enable_n)
    wait_lvl(0, 1'b1, n);
    `CHK("reset to disable", 26, n)
    `CHK("mated kept", 1'b1, mated)
    wait_lvl(2, 1'b0, n);
    `CHK("disable to unmated", 26, n)
    rd_chk(8'h4d, 8'h80);
    $display("test undock done");
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 1'b0;
    `CHK("idle enable_n", 1'b1, pins.dock_enable_n)
    `CHK("idle mated", 1'b0, mated)
    for (int i = 0; i < 8; i++)
      rd_chk(addr_tab[i], exp_tab[i]);
    for (int i = 0; i < 8; i++)
      if (i != 1 && i != 2)
      begin
        wr(addr_tab[i], 8'hff);
        rd_chk(addr_tab[i], exp_tab[i]);
      end
    $display("test map done");
    dock();
    undock();
    dock();
    @(negedge clk_sys_in);
    controller_reset_n_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    controller_reset_n_in = 1'b1;
    `CHK("controller_reset_n enable_n", 1'b1, pins.dock_enable_n)
    `CHK("controller_reset_n mated", 1'b0, mated)
    rd_chk(8'h4c, 8'h00);
    rd_chk(8'h4d, 8'h80);
    $display("test controller reset done");
    wr(8'h4d, 8'h00);
    rd_chk(8'h4d, 8'h00);
    wr(8'h4d, 8'h80);
    rd_chk(8'h4d, 8'h00);
    wr(8'h4c, 8'h01);
    rd_chk(8'h4c, 8'h00);
    repeat (60) @(negedge clk_sys_in);
    `CHK("locked enable_n", 1'b1, pins.dock_enable_n)
    $display("test write once done");
    `CHK("pin order before reset", 1'b0, order_err)
    rst_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    rst_in = 1'b0;
    rd_chk(8'h4d, 8'h80);
    dock();
    `CHK("pin order", 1'b0, order_err)
    $display("test platform reset done");
    stop_test();
  end
endmodule // dock_control_pm_capability_regs_tb
